// ==== design/tsc_timer_top.sv ====
/*
  Timer section control with the first timer: Avalon-MM slave, masked
  start/stop register, first timer configuration, reload and readback.
  Assumes tx/rx event and other-timer underflow inputs are one-cycle
  pulses from logic on clk_sys; the trimming oscillator is a pin.
*/
// Implementation choice: the Avalon-MM interface to the registers.
// Overview of operation
// - a start/stop write changes a high running bit only where its low mask bit is one.
// - mask bit n governs running bit n+4, so bit 3 drives bit 7 and bit 0 drives bit 4.
// - bits 7..4 report the four timers as running and start or stop them at once.
// - with halt-on-receive set the first timer stops when the first four bits arrive.
// - halt-on-receive has no effect while a trimming mode is selected.
// - auto-start 00 never starts the timer; 01 starts it at the end of a transmission.
// - auto-start 10 trims without underflow, 11 trims with it, both toggled on rising edges.
// - outside auto-start 10, with auto-reload set the counter reloads at zero and goes on, else it stops.
// - every underflow sets the timer underflow flag.
// - clock select 00 counts at 13.56 MHz and 01 at 211.875 kHz.
// - clock select 10 counts third timer underflows, 11 second timer underflows.
// - each start event loads the counter from the 16-bit reload value.
// - a reload write only acts at the next start event or auto-reload underflow.
module tsc_timer_top
  import tsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic txDone,
  input wire logic rxFirstBits,
  input wire logic secondTimerUnderflow,
  input wire logic thirdTimerUnderflow,
  input wire logic lowFreqOscillator,
  output logic [NUM_TIMERS-1:0] timerActive,
  output logic timerUnderflowFlag,
  output logic timerZeroUnderflow
);
  tsc_cnt_if cnt ();

  tsc_counter u_counter (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .cnt(cnt)
  );

  // bus slave
  logic [7:0] config_;
  logic [7:0] reloadHigh;
  logic [7:0] reloadLow;
  logic [NUM_TIMERS-1:1] otherActive;
  logic request;
  logic accept;
  logic wrLane;
  logic [7:0] wrByte;
  logic wrStartStop;
  logic wrConfig;
  logic wrReloadHi;
  logic wrReloadLo;
  logic wrFlag;
  logic [7:0] rdMux;
  logic [3:0] writeMask;
  logic [3:0] writeActive;

  assign request = avs_read || avs_write;
  // one wait state: data is latched while waitrequest is high
  assign accept = request && !avs_waitrequest;
  assign wrLane = avs_write && accept && avs_byteenable[0];
  assign wrByte = avs_writedata[7:0];
  assign wrStartStop = wrLane && avs_address == ADDR_START_STOP;
  assign wrConfig = wrLane && avs_address == ADDR_CONFIG;
  assign wrReloadHi = wrLane && avs_address == ADDR_RELOAD_HI;
  assign wrReloadLo = wrLane && avs_address == ADDR_RELOAD_LO;
  assign wrFlag = wrLane && avs_address == ADDR_FLAG;
  assign writeMask = wrByte[MASK_LSB+3:MASK_LSB];
  assign writeActive = wrByte[ACTIVE_LSB+3:ACTIVE_LSB];

  // mask bits are write-only and read back as zero
  assign rdMux =
    (avs_address == ADDR_START_STOP) ?
      {otherActive, cnt.running, 4'h0} :
    (avs_address == ADDR_CONFIG) ? config_ :
    (avs_address == ADDR_RELOAD_HI) ? reloadHigh :
    (avs_address == ADDR_RELOAD_LO) ? reloadLow :
    (avs_address == ADDR_COUNT_HI) ? cnt.count[15:8] :
    (avs_address == ADDR_COUNT_LO) ? cnt.count[7:0] :
    (avs_address == ADDR_FLAG) ? {7'h00, timerUnderflowFlag} :
    8'h00;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !(request && avs_waitrequest);
      if (request && avs_waitrequest) begin
        avs_readdata <= {24'h00_0000, rdMux};
      end
    end
  end

  // configuration and reload bytes
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      config_ <= CONFIG_RESET;
      reloadHigh <= RELOAD_RESET;
      reloadLow <= RELOAD_RESET;
    end else begin
      if (wrConfig) begin
        config_ <= wrByte & CFG_WRITABLE;
      end
      // reload bytes only feed the counter at a start event or an auto-reload underflow
      if (wrReloadHi) begin
        reloadHigh <= wrByte;
      end
      if (wrReloadLo) begin
        reloadLow <= wrByte;
      end
    end
  end

  // field decode
  logic haltOnReceive;
  logic [1:0] autoStartSource;
  logic reloadOnUnderflow;
  logic [1:0] countClockSelect;
  logic trimMode;
  assign haltOnReceive = config_[CFG_HALT_RX];
  assign autoStartSource = config_[CFG_AUTO_MSB:CFG_AUTO_LSB];
  assign reloadOnUnderflow = config_[CFG_RELOAD_UF];
  assign countClockSelect = config_[CFG_CLK_MSB:CFG_CLK_LSB];
  assign trimMode = autoStartSource[1];

  // fractional dividers: 13.56 MHz is not a sub-multiple of 25 MHz,
  // so ticks average the rate with one cycle of jitter
  localparam logic [ACC_W-1:0] RATE [2] = '{FAST_TICK_HZ, SLOW_TICK_HZ};
  logic [1:0] rateTick;
  genvar r;
  generate
    for (r = 0; r < 2; r++) begin : g_rate
      logic [ACC_W-1:0] acc;
      logic [ACC_W-1:0] sum;
      logic hit;
      assign sum = acc + RATE[r];
      assign hit = sum >= SYS_CLK_HZ;
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          acc <= '0;
          rateTick[r] <= 1'b0;
        end else begin
          acc <= hit ? sum - SYS_CLK_HZ : sum;
          rateTick[r] <= hit;
        end
      end
    end
  endgenerate

  // clock select
  logic selTick;
  assign selTick =
    (countClockSelect == CLK_FAST) ? rateTick[0] :
    (countClockSelect == CLK_SLOW) ? rateTick[1] :
    (countClockSelect == CLK_THIRD_UF) ? thirdTimerUnderflow :
    secondTimerUnderflow;

  // trimming oscillator pin: synchroniser then edge detect
  logic oscMeta;
  logic oscSync;
  logic oscLast;
  logic oscRise;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      oscMeta <= 1'b0;
      oscSync <= 1'b0;
      oscLast <= 1'b0;
    end else begin
      oscMeta <= lowFreqOscillator;
      oscSync <= oscMeta;
      oscLast <= oscSync;
    end
  end
  assign oscRise = oscSync && !oscLast;

  // start and stop events of the first timer
  logic swStart;
  logic swStop;
  logic txStart;
  logic trimStart;
  logic trimStop;
  logic rxHalt;
  assign swStart = wrStartStop && writeMask[0] && writeActive[0];
  assign swStop = wrStartStop && writeMask[0] && !writeActive[0];
  assign txStart = autoStartSource == AUTO_TX_END && txDone;
  assign trimStart = trimMode && oscRise && !cnt.running;
  assign trimStop = trimMode && oscRise && cnt.running;
  // receive halt is blanked in trimming modes
  assign rxHalt = haltOnReceive && !trimMode && rxFirstBits;

  assign cnt.start = swStart || txStart || trimStart;
  assign cnt.stop = swStop || trimStop || rxHalt;
  assign cnt.tick = selTick;
  assign cnt.autoReload = reloadOnUnderflow;
  assign cnt.holdAtZero = autoStartSource == AUTO_TRIM_HOLD;
  assign cnt.reload = {reloadHigh, reloadLow};

  // other timers' running bits, each behind its own mask bit
  genvar t;
  generate
    for (t = 1; t < NUM_TIMERS; t++) begin : g_active
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          otherActive[t] <= 1'b0;
        end else if (wrStartStop && writeMask[t]) begin
          otherActive[t] <= writeActive[t];
        end
      end
    end
  endgenerate

  // underflow flag: write one to clear, a new underflow wins
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      timerUnderflowFlag <= 1'b0;
      timerActive <= '0;
      timerZeroUnderflow <= 1'b0;
    end else begin
      if (cnt.underflow) begin
        timerUnderflowFlag <= 1'b1;
      end else if (wrFlag && wrByte[FLAG_BIT]) begin
        timerUnderflowFlag <= 1'b0;
      end
      timerActive <= {otherActive, cnt.running};
      timerZeroUnderflow <= cnt.underflow;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  a_mask_keeps: assert property (
    wrStartStop && !writeMask[1] |=> $stable(otherActive[1]))
    else $error("unmasked running bit changed");
  a_mask_map: assert property (
    wrStartStop && writeMask[3]
    |=> otherActive[3] == $past(writeActive[3]))
    else $error("mask bit 3 did not steer bit 7");
  a_sw_start: assert property (
    swStart |=> cnt.running ##1 timerActive[0])
    else $error("software start not seen");
  a_rx_halt: assert property (
    rxHalt && !cnt.start |=> !cnt.running)
    else $error("timer not halted on receive");
  a_trim_no_halt: assert property (
    trimMode && rxFirstBits && cnt.running && !oscRise && !wrStartStop
    && !(cnt.tick && cnt.count == 16'h0000) |=> cnt.running)
    else $error("receive halted a trimming timer");
  a_no_auto: assert property (
    autoStartSource == AUTO_NONE && !cnt.running && !swStart
    |=> !cnt.running)
    else $error("timer started by itself");
  a_tx_start: assert property (
    txStart |=> cnt.running && cnt.count == $past(cnt.reload))
    else $error("no load at end of transmission");
  a_trim_toggle: assert property (
    trimStart && !wrStartStop |=> cnt.running)
    else $error("trim edge did not start timer");
  a_third_clock: assert property (
    countClockSelect == CLK_THIRD_UF && thirdTimerUnderflow
    && cnt.running && cnt.count != 16'h0000 && !cnt.start && !cnt.stop
    |=> cnt.count == $past(cnt.count) - 16'h0001)
    else $error("third timer underflow not counted");
  // a clear write one cycle after the set may legally drop the flag
  a_flag_set: assert property (
    cnt.underflow
    |=> timerUnderflowFlag ##1 (timerUnderflowFlag || $past(wrFlag)))
    else $error("underflow flag not set");
  a_flag_clear: assert property (
    wrFlag && wrByte[FLAG_BIT] && !cnt.underflow |=> !timerUnderflowFlag)
    else $error("underflow flag not cleared");
  a_flag_pulse: assert property (
    cnt.underflow |=> timerZeroUnderflow)
    else $error("underflow pulse missing");
  a_mask_low: assert property (
    wrStartStop && writeMask[1]
    |=> otherActive[1] == $past(writeActive[1]))
    else $error("mask bit 1 did not steer bit 5");
  a_mask_mid: assert property (
    wrStartStop && writeMask[2]
    |=> otherActive[2] == $past(writeActive[2]))
    else $error("mask bit 2 did not steer bit 6");
  a_mask_idle: assert property (
    wrStartStop && writeMask == 4'h0 |=> $stable(otherActive))
    else $error("zero mask changed a running bit");
  a_status_read: assert property (
    avs_read && avs_waitrequest && avs_address == ADDR_START_STOP
    |=> avs_readdata[ACTIVE_LSB] == $past(cnt.running)
    && avs_readdata[ACTIVE_LSB+3:ACTIVE_LSB+1] == $past(otherActive))
    else $error("running bits not reported");
  a_sw_stop: assert property (
    swStop && !cnt.start |=> !cnt.running ##1 !timerActive[0])
    else $error("software stop not seen");
  a_rx_ignored: assert property (
    rxFirstBits && !haltOnReceive && cnt.running && !cnt.stop
    && !(cnt.tick && cnt.count == 16'h0000) |=> cnt.running)
    else $error("receive stopped a timer without halt-on-receive");
  a_tx_ignored: assert property (
    txDone && autoStartSource != AUTO_TX_END && !cnt.running
    && !swStart && !trimStart |=> !cnt.running)
    else $error("transmission end started a timer");
  a_trim_stop: assert property (
    trimStop && !cnt.start |=> !cnt.running)
    else $error("trim edge did not stop timer");
  a_hold_zero: assert property (
    cnt.holdAtZero && cnt.running && cnt.count == 16'h0000
    && !cnt.start && !cnt.stop
    |=> cnt.running && cnt.count == 16'h0000 && !cnt.underflow)
    else $error("trimming without underflow left zero");
  // one check per clock source; start and stop win over a tick
  a_fast_clock: assert property (
    countClockSelect == CLK_FAST && rateTick[0] && cnt.running
    && cnt.count != 16'h0000 && !cnt.start && !cnt.stop
    |=> cnt.count == $past(cnt.count) - 16'h0001)
    else $error("fast tick not counted");
  a_slow_clock: assert property (
    countClockSelect == CLK_SLOW && rateTick[1] && cnt.running
    && cnt.count != 16'h0000 && !cnt.start && !cnt.stop
    |=> cnt.count == $past(cnt.count) - 16'h0001)
    else $error("slow tick not counted");
  a_second_clock: assert property (
    countClockSelect == CLK_SECOND_UF && secondTimerUnderflow
    && cnt.running && cnt.count != 16'h0000 && !cnt.start && !cnt.stop
    |=> cnt.count == $past(cnt.count) - 16'h0001)
    else $error("second timer underflow not counted");
  a_sw_load: assert property (
    swStart |=> cnt.count == $past(cnt.reload))
    else $error("software start did not load reload value");
  a_reload_quiet: assert property (
    (wrReloadHi || wrReloadLo) && cnt.running && !cnt.start && !cnt.tick
    |=> $stable(cnt.count))
    else $error("reload write moved the count");
endmodule : tsc_timer_top

// ==== include/tsc_pkg.sv ====
/*
  Shared constants of the timer section: register indices and byte
  addresses, field positions, auto-start and clock-select encodings,
  divider rates. Assumes a 25 MHz system clock.
*/
package tsc_pkg;
  localparam int ADDR_W = 8;
  localparam int CNT_W = 16;
  // printed offsets are indices; byte address is four times the index
  localparam logic [7:0] IDX_START_STOP = 8'h0E;
  localparam logic [7:0] IDX_CONFIG = 8'h0F;
  localparam logic [7:0] IDX_RELOAD_HI = 8'h10;
  localparam logic [7:0] IDX_RELOAD_LO = 8'h11;
  localparam logic [7:0] IDX_COUNT_HI = 8'h12;
  localparam logic [7:0] IDX_COUNT_LO = 8'h13;
  localparam logic [7:0] IDX_FLAG = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_START_STOP = 8'h38;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 8'h3C;
  localparam logic [ADDR_W-1:0] ADDR_RELOAD_HI = 8'h40;
  localparam logic [ADDR_W-1:0] ADDR_RELOAD_LO = 8'h44;
  localparam logic [ADDR_W-1:0] ADDR_COUNT_HI = 8'h48;
  localparam logic [ADDR_W-1:0] ADDR_COUNT_LO = 8'h4C;
  localparam logic [ADDR_W-1:0] ADDR_FLAG = 8'h80;
  // start/stop register layout
  localparam int MASK_LSB = 0;
  localparam int ACTIVE_LSB = 4;
  localparam int NUM_TIMERS = 4;
  // config register layout
  localparam int CFG_HALT_RX = 7;
  localparam int CFG_AUTO_MSB = 5;
  localparam int CFG_AUTO_LSB = 4;
  localparam int CFG_RELOAD_UF = 3;
  localparam int CFG_CLK_MSB = 1;
  localparam int CFG_CLK_LSB = 0;
  localparam logic [7:0] CFG_WRITABLE = 8'hBB;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] RELOAD_RESET = 8'h00;
  localparam int FLAG_BIT = 0;
  // auto-start source encodings
  localparam logic [1:0] AUTO_NONE = 2'h0;
  localparam logic [1:0] AUTO_TX_END = 2'h1;
  localparam logic [1:0] AUTO_TRIM_HOLD = 2'h2;
  localparam logic [1:0] AUTO_TRIM_UF = 2'h3;
  // count clock select encodings
  localparam logic [1:0] CLK_FAST = 2'h0;
  localparam logic [1:0] CLK_SLOW = 2'h1;
  localparam logic [1:0] CLK_THIRD_UF = 2'h2;
  localparam logic [1:0] CLK_SECOND_UF = 2'h3;
  // rates in Hz for the fractional tick dividers
  localparam int ACC_W = 26;
  localparam logic [ACC_W-1:0] SYS_CLK_HZ = 26'h17D7840;
  localparam logic [ACC_W-1:0] FAST_TICK_HZ = 26'hCEE8C0;
  localparam logic [ACC_W-1:0] SLOW_TICK_HZ = 26'h33BA3;
endpackage : tsc_pkg

// ==== include/tsc_cnt_if.sv ====
/*
  Carrier between the register front end and the first timer's counter.
  Assumes both ends run on the same system clock.
*/
interface tsc_cnt_if;
  import tsc_pkg::*;
  logic tick;
  logic start;
  logic stop;
  logic autoReload;
  logic holdAtZero;
  logic [CNT_W-1:0] reload;
  logic [CNT_W-1:0] count;
  logic running;
  logic underflow;
  modport ctrl (output tick, start, stop, autoReload, holdAtZero, reload,
    input count, running, underflow);
  modport core (input tick, start, stop, autoReload, holdAtZero, reload,
    output count, running, underflow);
endinterface : tsc_cnt_if

// ==== design/tsc_counter.sv ====
/*
  Down counter of the first timer: load on start, decrement per tick,
  underflow with optional reload. Assumes start, stop and tick are
  one-cycle pulses on clk_sys.
*/
module tsc_counter
  import tsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  tsc_cnt_if.core cnt
);
  logic atZero;
  logic wrap;
  assign atZero = (cnt.count == '0);
  // trimming without underflow just parks at zero
  assign wrap = cnt.tick && cnt.running && atZero && !cnt.holdAtZero;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt.count <= '0;
      cnt.running <= 1'b0;
      cnt.underflow <= 1'b0;
    end else begin
      cnt.underflow <= 1'b0;
      if (cnt.start) begin
        cnt.count <= cnt.reload;
        cnt.running <= 1'b1;
      end else if (cnt.stop) begin
        cnt.running <= 1'b0;
      end else if (wrap) begin
        cnt.underflow <= 1'b1;
        if (cnt.autoReload) begin
          cnt.count <= cnt.reload;
        end else begin
          cnt.running <= 1'b0;
        end
      end else if (cnt.tick && cnt.running && !atZero) begin
        cnt.count <= cnt.count - 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  a_reload_on_wrap: assert property (
    wrap && cnt.autoReload && !cnt.start && !cnt.stop
    |=> cnt.running && cnt.count == $past(cnt.reload) && cnt.underflow)
    else $error("no reload after underflow");
  a_stop_at_zero: assert property (
    wrap && !cnt.autoReload && !cnt.start && !cnt.stop
    |=> !cnt.running ##1 !cnt.running || $past(cnt.start))
    else $error("timer kept running after zero");
  a_step_down: assert property (
    cnt.tick && cnt.running && !atZero && !cnt.start && !cnt.stop
    |=> cnt.count == $past(cnt.count) - 16'h0001)
    else $error("count did not drop by one");
  a_reload_isolated: assert property (
    !cnt.start && !cnt.tick |=> $stable(cnt.count))
    else $error("count moved without tick or start");
endmodule : tsc_counter

// ==== testbench/tb_timer_section_control_t0.sv ====
/*
  Self-checking bench of the timer section control block: Avalon-MM
  register traffic, event pulses and oscillator edges, read checks.
  Assumes the design's package and interface are compiled beforehand.
*/
module tb_timer_section_control_t0;
  timeunit 1ns;
  timeprecision 1ps;
  import tsc_pkg::*;

  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [ADDR_W-1:0] avsAddress = '0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = '0;
  logic [3:0] avsByteenable = '0;
  logic [31:0] avsReaddata;
  logic avsWaitrequest;
  logic txDone = 1'b0;
  logic rxFirstBits = 1'b0;
  logic secondUf = 1'b0;
  logic thirdUf = 1'b0;
  logic low_freq_oscillator = 1'b0;
  logic [NUM_TIMERS-1:0] timerActive;
  logic underflowFlag;
  logic zeroUnderflow;
  int mismatches = 0;
  int checkCount = 0;
  int ufPulses = 0;
  logic [31:0] expLo[$];
  logic [31:0] expHi[$];
  logic [31:0] rndState = 32'h6493;
  logic [7:0] ssExp;
  logic [7:0] wd;

  always #20 clk_sys = ~clk_sys;

  tsc_timer_top DUT (.clk_sys(clk_sys), .rst_b(rst_b),
    .avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite),
    .avs_writedata(avsWritedata), .avs_byteenable(avsByteenable),
    .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
    .txDone(txDone), .rxFirstBits(rxFirstBits),
    .secondTimerUnderflow(secondUf), .thirdTimerUnderflow(thirdUf),
    .lowFreqOscillator(low_freq_oscillator), .timerActive(timerActive),
    .timerUnderflowFlag(underflowFlag), .timerZeroUnderflow(zeroUnderflow));

  function automatic logic [31:0] nextRand(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nextRand

  task automatic endSim();
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : endSim

  task automatic check(logic [31:0] seen, logic [31:0] lo, logic [31:0] hi);
    logic ok;
    checkCount++;
    ok = (lo === hi) ? (seen === lo) : ((seen >= lo && seen <= hi) === 1'b1);
    if (!ok) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h..%h", $time, seen, lo, hi);
    end
  endtask : check

  // one access; held until waitrequest is seen low at a rising edge
  task automatic busCycle(logic rd, logic [7:0] a, logic [7:0] d,
      logic [3:0] be);
    int n;
    @(posedge clk_sys);
    avsAddress <= a;
    avsWritedata <= {24'h000000, d};
    avsByteenable <= be;
    avsRead <= rd;
    avsWrite <= ~rd;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      if (avsWaitrequest === 1'b0) break;
    end
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    if (n == 20) begin
      mismatches++;
      $display("[ERR] %0t bus access never answered", $time);
      endSim();
    end
  endtask : busCycle

  task automatic wr(logic [7:0] a, logic [7:0] d);
    busCycle(1'b0, a, d, 4'hF);
  endtask : wr

  task automatic rdRange(logic [7:0] a, logic [7:0] lo, logic [7:0] hi);
    expLo.push_back({24'h000000, lo});
    expHi.push_back({24'h000000, hi});
    busCycle(1'b1, a, 8'h00, 4'hF);
  endtask : rdRange

  task automatic rd(logic [7:0] a, logic [7:0] e);
    rdRange(a, e, e);
  endtask : rd

  // sel 0 tx end, 1 first rx bits, 2 second uf, 3 third uf
  task automatic pulses(int sel, int n);
    repeat (n) begin
      @(posedge clk_sys);
      txDone <= (sel == 0);
      rxFirstBits <= (sel == 1);
      secondUf <= (sel == 2);
      thirdUf <= (sel == 3);
      @(posedge clk_sys);
      {txDone, rxFirstBits, secondUf, thirdUf} <= 4'h0;
    end
  endtask : pulses

  task automatic lfoEdge();
    @(posedge clk_sys);
    low_freq_oscillator <= 1'b0;
    repeat (6) @(posedge clk_sys);
    low_freq_oscillator <= 1'b1;
    repeat (6) @(posedge clk_sys);
  endtask : lfoEdge

  // the underflow pulse stands one cycle only
  always @(posedge clk_sys) begin
    if (zeroUnderflow === 1'b1) ufPulses++;
  end

  // read results stand in the cycle waitrequest is low
  always @(posedge clk_sys) begin
    if (avsRead === 1'b1 && avsWaitrequest === 1'b0) begin
      if (expLo.size() == 0) begin
        mismatches++;
        $display("[ERR] %0t read result without expectation", $time);
      end else begin
        check(avsReaddata, expLo.pop_front(), expHi.pop_front());
      end
    end
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    foreach (ssExp[i]) rd(ADDR_START_STOP, 8'h00);
    rd(ADDR_CONFIG, CONFIG_RESET);
    rd(ADDR_RELOAD_LO, RELOAD_RESET);
    rd(ADDR_FLAG, 8'h00);
    wr(ADDR_RELOAD_HI, 8'hA5);
    busCycle(1'b0, ADDR_RELOAD_HI, 8'h5A, 4'h0);
    rd(ADDR_RELOAD_HI, 8'hA5);
    wr(8'h84, 8'hFF);
    rd(8'h84, 8'h00);
    wr(ADDR_CONFIG, 8'hFF);
    rd(ADDR_CONFIG, CFG_WRITABLE);
    wr(ADDR_CONFIG, 8'h00);
    wr(ADDR_START_STOP, 8'hF0);
    rd(ADDR_START_STOP, 8'h00);
    wr(ADDR_START_STOP, 8'h88);
    rd(ADDR_START_STOP, 8'h80);
    check({28'h0000000, timerActive}, 32'h8, 32'h8);
    wr(ADDR_START_STOP, 8'hFF);
    rd(ADDR_START_STOP, 8'hF0);
    wr(ADDR_START_STOP, 8'h0F);
    rd(ADDR_START_STOP, 8'h00);
    // first timer kept out: its bit also moves on its own events
    ssExp = 8'h00;
    repeat (8) begin
      rndState = nextRand(rndState);
      wd = rndState[7:0] & 8'hEE;
      ssExp = (ssExp & ~{wd[3:0], 4'h0}) | (wd & {wd[3:0], 4'h0});
      wr(ADDR_START_STOP, wd);
      rd(ADDR_START_STOP, ssExp);
    end
    wr(ADDR_START_STOP, 8'h0F);
    wr(ADDR_RELOAD_HI, 8'h00);
    wr(ADDR_RELOAD_LO, 8'h05);
    wr(ADDR_CONFIG, 8'h03);
    wr(ADDR_START_STOP, 8'h11);
    rd(ADDR_COUNT_LO, 8'h05);
    pulses(2, 2);
    rd(ADDR_COUNT_LO, 8'h03);
    wr(ADDR_RELOAD_LO, 8'h09);
    rd(ADDR_COUNT_LO, 8'h03);
    pulses(3, 2);
    rd(ADDR_COUNT_LO, 8'h03);
    pulses(2, 3);
    rd(ADDR_FLAG, 8'h00);
    pulses(2, 1);
    rd(ADDR_START_STOP, 8'h00);
    rd(ADDR_FLAG, 8'h01);
    check({31'h00000000, underflowFlag}, 32'h1, 32'h1);
    wr(ADDR_FLAG, 8'h01);
    rd(ADDR_FLAG, 8'h00);
    check({31'h00000000, underflowFlag}, 32'h0, 32'h0);
    wr(ADDR_CONFIG, 8'h0A);
    wr(ADDR_START_STOP, 8'h11);
    rd(ADDR_COUNT_LO, 8'h09);
    pulses(3, 10);
    rd(ADDR_COUNT_LO, 8'h09);
    rd(ADDR_START_STOP, 8'h10);
    wr(ADDR_START_STOP, 8'h01);
    wr(ADDR_CONFIG, 8'h03);
    pulses(0, 1);
    rd(ADDR_START_STOP, 8'h00);
    wr(ADDR_CONFIG, 8'h13);
    pulses(0, 1);
    rd(ADDR_START_STOP, 8'h10);
    pulses(1, 1);
    rd(ADDR_START_STOP, 8'h10);
    wr(ADDR_CONFIG, 8'h93);
    pulses(1, 1);
    rd(ADDR_START_STOP, 8'h00);
    wr(ADDR_CONFIG, 8'hB3);
    wr(ADDR_START_STOP, 8'h11);
    pulses(1, 1);
    rd(ADDR_START_STOP, 8'h10);
    wr(ADDR_START_STOP, 8'h01);
    wr(ADDR_FLAG, 8'h01);
    wr(ADDR_CONFIG, 8'h20);
    lfoEdge();
    repeat (40) @(posedge clk_sys);
    rd(ADDR_START_STOP, 8'h10);
    rd(ADDR_COUNT_LO, 8'h00);
    rd(ADDR_FLAG, 8'h00);
    lfoEdge();
    rd(ADDR_START_STOP, 8'h00);
    wr(ADDR_CONFIG, 8'h30);
    lfoEdge();
    repeat (40) @(posedge clk_sys);
    rd(ADDR_START_STOP, 8'h00);
    rd(ADDR_FLAG, 8'h01);
    wr(ADDR_CONFIG, 8'h00);
    wr(ADDR_RELOAD_HI, 8'hFF);
    wr(ADDR_RELOAD_LO, 8'hFF);
    wr(ADDR_START_STOP, 8'h11);
    repeat (200) @(posedge clk_sys);
    rdRange(ADDR_COUNT_LO, 8'h8D, 8'h97);
    wr(ADDR_START_STOP, 8'h01);
    wr(ADDR_CONFIG, 8'h01);
    wr(ADDR_START_STOP, 8'h11);
    repeat (1180) @(posedge clk_sys);
    rdRange(ADDR_COUNT_LO, 8'hF3, 8'hF7);
    repeat (3) @(posedge clk_sys);
    check(ufPulses, 32'h3, 32'h3);
    endSim();
  end
endmodule : tb_timer_section_control_t0
